// ===== bench/pieb_event_src.sv
`timescale 1ns/1ps
module pieb_event_src (
	input  wire logic       clk_in,
	input  wire logic [5:0] fire_in,
	output logic      [5:0] event_out
);
	// One-cycle strobes, the way a real event source reports
	always_ff @(posedge clk_in) begin
		event_out <= fire_in;
	end
endmodule : pieb_event_src

// ===== bench/pieb_irq_enable_bank_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module pieb_irq_enable_bank_tb_top;
	import pieb_pkg::*;
	logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hready, irq;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = PIEB_HSIZE_WORD;
	logic        hresp;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [7:0]  irq_req, en;
	logic [5:0]  fire = 0, ev;
	int          miscompares = 0, comparisons = 0;
	always #25 clk = ~clk;
	pieb_event_src pieb_event_src_inst (.clk_in(clk), .fire_in(fire), .event_out(ev));
	pieb_irq_enable_bank pieb_irq_enable_bank_inst (.CLOCK_IN(clk), .RST_N_IN(rst_n),
		.HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
		.HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
		.HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
		.TIMER_SIX_MATCH_IN(ev[5]), .COMPARATOR_TWO_IN(ev[4]), .COMPARATOR_ONE_IN(ev[3]),
		.NONVOLATILE_DONE_IN(ev[2]), .TIMER_FOUR_MATCH_IN(ev[1]),
		.OSCILLATOR_ROLLOVER_IN(ev[0]), .IRQ_REQ_OUT(irq_req), .IRQ_OUT(irq));
	function automatic logic [7:0] xp(input logic [5:0] f);
		return {f[5:2], 2'b00, f[1:0]};
	endfunction : xp
	task automatic finish_test();
		$display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test
	// Select stays high between transfers so no signal is driven twice in one step
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do begin @(posedge clk); n++; end while (!hready && n < 50);
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge clk); n++; end while (!hready && n < 50);
		rd = hrdata;
		if (n >= 50) begin
			miscompares++;
			finish_test();
		end
	endtask : bus
	initial begin
		void'($urandom(32'h6afaa6d2));
		repeat (3) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		bus(0, PIEB_OFF_ENABLE, 0);
		`CHK(rd, {24'h0, PIEB_ENABLE_RST})
		bus(0, 8'h40, 0);
		`CHK(rd, 32'h0)
		for (int i = 0; i < 10; i++) begin
			logic [5:0] f;
			en = (i == 0) ? 8'hff : 8'($urandom);
			f = (i < 2) ? 6'h3f : 6'($urandom);
			bus(1, PIEB_OFF_ENABLE, {24'h0, en});
			bus(0, PIEB_OFF_ENABLE, 0);
			`CHK(rd, {24'h0, en & PIEB_IMPL_MASK})
			fire <= f;
			@(posedge clk);
			fire <= 0;
			repeat (2) @(posedge clk);
			`CHK(irq_req, xp(f) & en)
			`CHK(irq, |(xp(f) & en))
			bus(0, PIEB_OFF_FLAG, 0);
			`CHK(rd, {24'h0, xp(f)})
			`CHK(hresp, PIEB_HRESP_OKAY)
			bus(1, PIEB_OFF_FLAG, 32'hff);
			@(posedge clk);
			`CHK(irq_req, 8'h00)
			$display("Test %0d done", i);
		end
		// Events land in the same cycle as their write-one clear
		fork
			bus(1, PIEB_OFF_FLAG, 32'hff);
			begin
				fire <= 6'h3f;
				@(posedge clk);
				fire <= 6'h00;
			end
		join
		bus(0, PIEB_OFF_FLAG, 0);
		`CHK(rd, {24'h0, PIEB_IMPL_MASK})
		// A byte-sized write must leave the enables alone
		hsize <= 3'h0;
		bus(1, PIEB_OFF_ENABLE, 32'hff);
		hsize <= PIEB_HSIZE_WORD;
		bus(0, PIEB_OFF_ENABLE, 0);
		`CHK(rd, {24'h0, en & PIEB_IMPL_MASK})
		$display("Corner tests done");
		// Reset in mid-run with flags standing
		rst_n <= 0;
		repeat (2) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		`CHK(irq, 1'b0)
		bus(0, PIEB_OFF_ENABLE, 0);
		`CHK(rd, {24'h0, PIEB_ENABLE_RST})
		bus(0, PIEB_OFF_FLAG, 0);
		`CHK(rd, {24'h0, PIEB_FLAG_RST})
		$display("Reset test done");
		finish_test();
	end
endmodule : pieb_irq_enable_bank_tb_top

// ===== src/pieb_irq_enable_bank.sv
`timescale 1ns/1ps
module pieb_irq_enable_bank
	import pieb_pkg::*;
(
	// Clock and reset
	input  wire logic        CLOCK_IN,
	input  wire logic        RST_N_IN,
	// AHB-Lite slave
	input  wire logic        HSEL_IN,
	input  wire logic [31:0] HADDR_IN,
	input  wire logic [1:0]  HTRANS_IN,
	input  wire logic        HWRITE_IN,
	input  wire logic [2:0]  HSIZE_IN,
	input  wire logic [31:0] HWDATA_IN,
	input  wire logic        HREADY_IN,
	output logic      [31:0] HRDATA_OUT,
	output logic             HREADYOUT_OUT,
	output logic             HRESP_OUT,
	// Peripheral events, same clock domain
	input  wire logic        TIMER_SIX_MATCH_IN,
	input  wire logic        COMPARATOR_TWO_IN,
	input  wire logic        COMPARATOR_ONE_IN,
	input  wire logic        NONVOLATILE_DONE_IN,
	input  wire logic        TIMER_FOUR_MATCH_IN,
	input  wire logic        OSCILLATOR_ROLLOVER_IN,
	// Requests toward the core
	output logic      [7:0]  IRQ_REQ_OUT,
	output logic             IRQ_OUT
);

	////////////////////////////////////////////////////////////////////////
	// State

	pieb_state_s s_q;
	pieb_state_s s_d;
	logic [7:0]  evt;
	logic        acc;
	logic        wr_en;
	logic        wr_flag;
	pieb_sel_e   sel;

	logic [7:0]  flag_nxt;
	logic [7:0]  clr_hit;

	// Events packed into the register layout; the holes stay low
	assign evt = {TIMER_SIX_MATCH_IN, COMPARATOR_TWO_IN, COMPARATOR_ONE_IN,
		NONVOLATILE_DONE_IN, 2'b00, TIMER_FOUR_MATCH_IN, OSCILLATOR_ROLLOVER_IN};

	// Data phase decode straight from the registered address phase
	assign wr_en   = (s_q.wr_sel == PIEB_SEL_ENABLE);
	assign wr_flag = (s_q.wr_sel == PIEB_SEL_FLAG);

	////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	// The event packing above hard-wires these slots
	if (PIEB_BIT_TIMER_SIX != 7 || PIEB_BIT_COMP_TWO != 6 || PIEB_BIT_COMP_ONE != 5 ||
		PIEB_BIT_NVM_DONE != 4 || PIEB_BIT_TIMER_FOUR != 1 ||
		PIEB_BIT_OSC_ROLL != 0) begin : g_bad_layout
		$error("event slots do not match the packing");
	end

	// Only the upper four and lower two slots may hold enables
	if ((PIEB_IMPL_MASK & 8'h0c) != 8'h00) begin : g_bad_mask
		$error("implemented mask covers an empty slot");
	end

	// Two distinct word-aligned registers
	if (PIEB_OFF_ENABLE[1:0] != 2'b00 || PIEB_OFF_FLAG[1:0] != 2'b00 ||
		PIEB_OFF_ENABLE == PIEB_OFF_FLAG) begin : g_bad_map
		$error("register offsets overlap or are not word aligned");
	end

	// Reset values must not set an empty slot
	if (((PIEB_ENABLE_RST | PIEB_FLAG_RST) & ~PIEB_IMPL_MASK) != 8'h00) begin : g_bad_rst
		$error("reset value sets an unimplemented bit");
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky flags, one slice per bit

	for (genvar b = 0; b < 8; b++) begin : g_flag
		if (PIEB_IMPL_MASK[b]) begin : g_impl
			// Event set beats a write-one clear in the same cycle
			assign clr_hit[b]  = wr_flag & HWDATA_IN[b];
			assign flag_nxt[b] = evt[b] | (s_q.flag[b] & ~clr_hit[b]);
		end else begin : g_hole
			assign clr_hit[b]  = 1'b0;
			assign flag_nxt[b] = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_d = s_q;
		// Write data phase
		if (wr_en) begin
			s_d.en = HWDATA_IN[7:0] & PIEB_IMPL_MASK;
		end
		s_d.flag = flag_nxt;
		// Per-source gating by the enable bits
		s_d.req = s_d.flag & s_d.en;
		s_d.irq = |s_d.req;
		// Address phase; upper address bits are not decoded
		acc = HSEL_IN & HREADY_IN & HTRANS_IN[1];
		if (HADDR_IN[7:0] == PIEB_OFF_ENABLE) begin
			sel = PIEB_SEL_ENABLE;
		end else if (HADDR_IN[7:0] == PIEB_OFF_FLAG) begin
			sel = PIEB_SEL_FLAG;
		end else begin
			sel = PIEB_SEL_NONE;
		end
		s_d.wr_sel = (acc && HWRITE_IN && HSIZE_IN == PIEB_HSIZE_WORD) ? sel : PIEB_SEL_NONE;
		// Read data taken from next state so a write just before is seen
		s_d.rdata = 32'h0;
		if (acc && !HWRITE_IN) begin
			unique case (sel)
				PIEB_SEL_ENABLE: s_d.rdata = {24'h0, s_d.en & PIEB_IMPL_MASK};
				PIEB_SEL_FLAG:   s_d.rdata = {24'h0, s_d.flag};
				PIEB_SEL_NONE:   s_d.rdata = 32'h0;
			endcase
		end
		s_d.ready = 1'b1;
		s_d.resp  = PIEB_HRESP_OKAY;
	end

	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			s_q.en     <= PIEB_ENABLE_RST;
			s_q.flag   <= PIEB_FLAG_RST;
			s_q.req    <= 8'h00;
			s_q.irq    <= 1'b0;
			s_q.wr_sel <= PIEB_SEL_NONE;
			s_q.rdata  <= 32'h0;
			s_q.ready  <= 1'b1;
			s_q.resp   <= PIEB_HRESP_OKAY;
		end else begin
			s_q <= s_d;
		end
	end

	assign HRDATA_OUT    = s_q.rdata;
	assign HREADYOUT_OUT = s_q.ready;
	assign HRESP_OUT     = s_q.resp;
	assign IRQ_REQ_OUT   = s_q.req;
	assign IRQ_OUT       = s_q.irq;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!RST_N_IN);

	timer_six_gate_a: assert property (
		!s_q.en[PIEB_BIT_TIMER_SIX] && !wr_en |=> !IRQ_REQ_OUT[PIEB_BIT_TIMER_SIX])
		else $error("timer six request while disabled");

	comp_two_gate_a: assert property (
		s_q.flag[PIEB_BIT_COMP_TWO] && s_q.en[PIEB_BIT_COMP_TWO] && !wr_en && !wr_flag
		|=> IRQ_REQ_OUT[PIEB_BIT_COMP_TWO] && IRQ_OUT)
		else $error("comparator two request lost");

	comp_one_gate_a: assert property (
		IRQ_REQ_OUT[PIEB_BIT_COMP_ONE] |-> s_q.en[PIEB_BIT_COMP_ONE])
		else $error("comparator one request without enable");

	nvm_done_gate_a: assert property (
		NONVOLATILE_DONE_IN && s_q.en[PIEB_BIT_NVM_DONE] && !wr_en
		|=> IRQ_REQ_OUT[PIEB_BIT_NVM_DONE] && IRQ_OUT)
		else $error("nonvolatile done did not raise request");

	timer_four_gate_a: assert property (
		$fell(s_q.en[PIEB_BIT_TIMER_FOUR]) |-> !IRQ_REQ_OUT[PIEB_BIT_TIMER_FOUR])
		else $error("timer four request after disable");

	osc_roll_gate_a: assert property (
		(!s_q.en[PIEB_BIT_OSC_ROLL] && !wr_en) [*2] |-> !IRQ_REQ_OUT[PIEB_BIT_OSC_ROLL])
		else $error("oscillator request while disabled");

	unimpl_bits_a: assert property (
		wr_en |=> s_q.en == ($past(HWDATA_IN[7:0]) & PIEB_IMPL_MASK) && !s_q.en[3] && !s_q.en[2])
		else $error("enable write wrong or unimplemented bits set");

	////////////////////////////////////////////////////////////////////////
	// Bus side checks

	irq_level_a: assert property (
		IRQ_OUT == (|IRQ_REQ_OUT))
		else $error("interrupt line disagrees with requests");

	irq_source_a: assert property (
		IRQ_OUT |-> (s_q.flag & s_q.en) != 8'h00)
		else $error("interrupt line without an enabled flag");

	// Clearing every standing flag with no new event drops the line
	irq_clear_a: assert property (
		wr_flag && (HWDATA_IN[7:0] & s_q.flag) == s_q.flag && evt == 8'h00
		|=> !IRQ_OUT)
		else $error("interrupt line stayed up after a full clear");

	enable_mask_a: assert property (
		(s_q.en & ~PIEB_IMPL_MASK) == 8'h00)
		else $error("enable holds an unimplemented bit");

	bus_okay_a: assert property (
		HREADYOUT_OUT && HRESP_OUT == PIEB_HRESP_OKAY)
		else $error("slave stalled or answered with an error");

	read_enable_a: assert property (
		acc && !HWRITE_IN && HADDR_IN[7:0] == PIEB_OFF_ENABLE
		|=> HRDATA_OUT == {24'h0, s_q.en})
		else $error("enable read back wrong");

	read_flag_a: assert property (
		acc && !HWRITE_IN && HADDR_IN[7:0] == PIEB_OFF_FLAG
		|=> HRDATA_OUT == {24'h0, s_q.flag})
		else $error("flag read back wrong");

	// A read right behind a write must already see the new enables
	read_after_write_a: assert property (
		wr_en && acc && !HWRITE_IN && HADDR_IN[7:0] == PIEB_OFF_ENABLE
		|=> HRDATA_OUT[7:0] == ($past(HWDATA_IN[7:0]) & PIEB_IMPL_MASK))
		else $error("read behind a write saw stale enables");

	read_idle_a: assert property (
		!(acc && !HWRITE_IN) |=> HRDATA_OUT == 32'h0)
		else $error("read data outside a read data phase");

	read_holes_a: assert property (
		HRDATA_OUT[31:8] == 24'h0 && HRDATA_OUT[3:2] == 2'b00)
		else $error("unused read bits not zero");

	enable_select_a: assert property (
		acc && HWRITE_IN && HSIZE_IN == PIEB_HSIZE_WORD
		&& HADDR_IN[7:0] == PIEB_OFF_ENABLE |=> wr_en)
		else $error("enable write not accepted");

	flag_select_a: assert property (
		acc && HWRITE_IN && HSIZE_IN == PIEB_HSIZE_WORD
		&& HADDR_IN[7:0] == PIEB_OFF_FLAG |=> wr_flag)
		else $error("flag write not accepted");

	narrow_write_a: assert property (
		acc && HWRITE_IN && HSIZE_IN != PIEB_HSIZE_WORD |=> s_q.wr_sel == PIEB_SEL_NONE)
		else $error("narrow write accepted");

	unmapped_write_a: assert property (
		acc && HWRITE_IN && HADDR_IN[7:0] != PIEB_OFF_ENABLE
		&& HADDR_IN[7:0] != PIEB_OFF_FLAG |=> s_q.wr_sel == PIEB_SEL_NONE)
		else $error("write to an unmapped offset accepted");

	write_hold_a: assert property (
		!wr_en |=> $stable(s_q.en))
		else $error("enables changed without a write");

	clear_idle_a: assert property (
		!wr_flag |-> clr_hit == 8'h00)
		else $error("flag clear outside a flag write");

	////////////////////////////////////////////////////////////////////////
	// Per-bit checks

	for (genvar b = 0; b < 8; b++) begin : g_chk
		if (PIEB_IMPL_MASK[b]) begin : g_impl
			gate_block_a: assert property (
				!s_q.en[b] && !wr_en |=> !IRQ_REQ_OUT[b])
				else $error("request raised while its enable is clear");

			gate_pass_a: assert property (
				evt[b] && s_q.en[b] && !wr_en |=> IRQ_REQ_OUT[b] && IRQ_OUT)
				else $error("enabled event raised no request");

			req_rise_a: assert property (
				$rose(IRQ_REQ_OUT[b]) |-> s_q.en[b] && s_q.flag[b])
				else $error("request rose without flag and enable");

			en_write_a: assert property (
				wr_en |=> s_q.en[b] == $past(HWDATA_IN[b]))
				else $error("enable bit did not take the written value");

			set_wins_a: assert property (
				evt[b] && clr_hit[b] |=> s_q.flag[b])
				else $error("clear beat a same-cycle event");

			w1c_clear_a: assert property (
				s_q.flag[b] && clr_hit[b] && !evt[b] |=> !s_q.flag[b])
				else $error("write-one clear left the flag set");

			flag_hold_a: assert property (
				s_q.flag[b] && !clr_hit[b] |=> s_q.flag[b])
				else $error("sticky flag dropped without a clear");

			flag_source_a: assert property (
				$rose(s_q.flag[b]) |-> $past(evt[b]))
				else $error("flag set without its event");
		end else begin : g_hole
			hole_zero_a: assert property (
				!s_q.en[b] && !s_q.flag[b] && !IRQ_REQ_OUT[b])
				else $error("unimplemented bit set");
		end
	end

endmodule : pieb_irq_enable_bank

// ===== src/pieb_pkg.sv
// Function
// - Timer-six period match may interrupt only while enable bit 7 is one
// - Second comparator may interrupt only while enable bit 6 is set
// - First comparator may interrupt only while enable bit 5 is set
// - Nonvolatile memory task done may interrupt only while enable bit 4 is one
// - Timer-four period match may interrupt only while enable bit 1 is one
// - Oscillator rollover may interrupt only while enable bit 0 is set
package pieb_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map (byte addresses, low eight address bits decoded)
	localparam logic [7:0]  PIEB_OFF_ENABLE = 8'h00;
	localparam logic [7:0]  PIEB_OFF_FLAG   = 8'h04;

	////////////////////////////////////////////////////////////////////////
	// Field positions of the enable and flag registers
	localparam int          PIEB_BIT_TIMER_SIX  = 7;
	localparam int          PIEB_BIT_COMP_TWO   = 6;
	localparam int          PIEB_BIT_COMP_ONE   = 5;
	localparam int          PIEB_BIT_NVM_DONE   = 4;
	localparam int          PIEB_BIT_TIMER_FOUR = 1;
	localparam int          PIEB_BIT_OSC_ROLL   = 0;
	localparam logic [7:0]  PIEB_IMPL_MASK      = 8'hf3;
	localparam logic [7:0]  PIEB_ENABLE_RST     = 8'h00;
	localparam logic [7:0]  PIEB_FLAG_RST       = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Bus encodings
	localparam logic [2:0]  PIEB_HSIZE_WORD = 3'h2;
	localparam logic        PIEB_HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {
		PIEB_SEL_NONE,
		PIEB_SEL_ENABLE,
		PIEB_SEL_FLAG
	} pieb_sel_e;

	typedef struct packed {
		logic [7:0]  en;
		logic [7:0]  flag;
		logic [7:0]  req;
		logic        irq;
		pieb_sel_e   wr_sel;
		logic [31:0] rdata;
		logic        ready;
		logic        resp;
	} pieb_state_s;

endpackage : pieb_pkg
